// File: logic/sbda_regs.vh
// Address map, decode selects and timing-free constants of the bus fabric
`ifndef SBDA_REGS_VH
`define SBDA_REGS_VH

// ======================================================================
// Region bases and limits (limit is first address past the region)
`define SBDA_REMAP_BASE      32'h0000_0000
`define SBDA_REMAP_LIMIT     32'h0400_0000
`define SBDA_ROM_BASE        32'h07f0_0000
`define SBDA_ROM_LIMIT       32'h07f2_4000
`define SBDA_OTPREG_BASE     32'h07f4_0000
`define SBDA_OTPREG_LIMIT    32'h07f4_0100
`define SBDA_OTP_BASE        32'h07f8_0000
`define SBDA_OTP_LIMIT       32'h07f8_8000
`define SBDA_RAM_BASE        32'h07fc_0000
`define SBDA_RAM2_BASE       32'h07fc_4000
`define SBDA_RAM3_BASE       32'h07fc_7000
`define SBDA_RAM_LIMIT       32'h07fc_c000
`define SBDA_LLREG_BASE      32'h4000_0000
`define SBDA_RADIO_BASE      32'h4000_1000
`define SBDA_RADIO_LIMIT     32'h4000_4000
`define SBDA_SLP_BASE        32'h5000_0000
`define SBDA_SLP_LIMIT       32'h5000_0300
`define SBDA_SYSA_BASE       32'h5000_1000
`define SBDA_SYSA_LIMIT      32'h5000_1700
`define SBDA_SYSB_BASE       32'h5000_3000
`define SBDA_SYSB_LIMIT      32'h5000_3700
`define SBDA_TIM_BASE        32'h5000_4000
`define SBDA_TIM_LIMIT       32'h5000_4200
`define SBDA_PPB_BASE        32'he000_0000
`define SBDA_PPB_LIMIT       32'he010_0000

// ======================================================================
// Peripheral window geometry and boot remap offset mask
`define SBDA_WIN_LSB         8
`define SBDA_WIN_IDX_W       3
`define SBDA_OFS_MASK        32'h03ff_ffff

// ======================================================================
// AHB slave select indices
`define SBDA_NSLV            8
`define SBDA_SLV_ROM         3'h0
`define SBDA_SLV_OTPREG      3'h1
`define SBDA_SLV_OTP         3'h2
`define SBDA_SLV_RAM         3'h3
`define SBDA_SLV_LLREG       3'h4
`define SBDA_SLV_RADIO       3'h5
`define SBDA_SLV_PPB         3'h6
`define SBDA_SLV_APB         3'h7

// ======================================================================
// Boot remap codes
`define SBDA_REMAP_ROM       2'h0
`define SBDA_REMAP_OTP       2'h1
`define SBDA_REMAP_RAM       2'h2

// ======================================================================
// APB group codes by power domain
`define SBDA_GRP_NONE        2'h0
`define SBDA_GRP_SLP         2'h1
`define SBDA_GRP_SYS         2'h2
`define SBDA_GRP_TIM         2'h3

// ======================================================================
// AHB transfer encodings and master priority code
`define SBDA_HTRANS_IDLE     2'h0
`define SBDA_HTRANS_NONSEQ   2'h2
`define SBDA_PRIO_CPU        1'b0

`endif

// File: logic/sbda_addr_decode.v
// Combinational address decoder of the bus fabric
`timescale 1ns/100ps
`include "sbda_regs.vh"

module sbda_addr_decode (
  // Address and remap
  input  wire [31:0] addr_in,
  input  wire [1:0]  boot_remap_select_in,
  // Decode result
  output reg  [2:0]  slave_idx_out,
  output reg         hit_out,
  output reg  [1:0]  apb_group_out,
  output reg         apb_wide_out,
  output reg  [2:0]  apb_window_out,
  output reg  [1:0]  ram_bank_out,
  output reg  [31:0] phys_addr_out
);

  reg [31:0] a;

  always @* begin
    a = addr_in;
    if (addr_in < `SBDA_REMAP_LIMIT) begin
      case (boot_remap_select_in)
        `SBDA_REMAP_OTP: a = `SBDA_OTP_BASE | (addr_in & `SBDA_OFS_MASK);
        `SBDA_REMAP_RAM: a = `SBDA_RAM_BASE | (addr_in & `SBDA_OFS_MASK);
        default:         a = `SBDA_ROM_BASE | (addr_in & `SBDA_OFS_MASK);
      endcase
    end
    phys_addr_out  = a;
    slave_idx_out  = `SBDA_SLV_ROM;
    hit_out        = 1'b0;
    apb_group_out  = `SBDA_GRP_NONE;
    apb_wide_out   = 1'b0;
    apb_window_out = a[`SBDA_WIN_LSB+`SBDA_WIN_IDX_W-1:`SBDA_WIN_LSB];
    ram_bank_out   = 2'h0;
    if (a >= `SBDA_ROM_BASE && a < `SBDA_ROM_LIMIT) begin
      slave_idx_out = `SBDA_SLV_ROM;
      hit_out       = 1'b1;
    end else if (a >= `SBDA_OTPREG_BASE && a < `SBDA_OTPREG_LIMIT) begin
      slave_idx_out = `SBDA_SLV_OTPREG;
      hit_out       = 1'b1;
    end else if (a >= `SBDA_OTP_BASE && a < `SBDA_OTP_LIMIT) begin
      slave_idx_out = `SBDA_SLV_OTP;
      hit_out       = 1'b1;
    end else if (a >= `SBDA_RAM_BASE && a < `SBDA_RAM_LIMIT) begin
      slave_idx_out = `SBDA_SLV_RAM;
      hit_out       = 1'b1;
      if (a >= `SBDA_RAM3_BASE)
        ram_bank_out = 2'h2;
      else if (a >= `SBDA_RAM2_BASE)
        ram_bank_out = 2'h1;
      else
        ram_bank_out = 2'h0;
    end else if (a >= `SBDA_LLREG_BASE && a < `SBDA_RADIO_BASE) begin
      slave_idx_out = `SBDA_SLV_LLREG;
      hit_out       = 1'b1;
    end else if (a >= `SBDA_RADIO_BASE && a < `SBDA_RADIO_LIMIT) begin
      slave_idx_out = `SBDA_SLV_RADIO;
      hit_out       = 1'b1;
    end else if (a >= `SBDA_SLP_BASE && a < `SBDA_SLP_LIMIT) begin
      slave_idx_out = `SBDA_SLV_APB;
      hit_out       = 1'b1;
      apb_group_out = `SBDA_GRP_SLP;
    end else if (a >= `SBDA_SYSA_BASE && a < `SBDA_SYSA_LIMIT) begin
      slave_idx_out = `SBDA_SLV_APB;
      hit_out       = 1'b1;
      apb_group_out = `SBDA_GRP_SYS;
    end else if (a >= `SBDA_SYSB_BASE && a < `SBDA_SYSB_LIMIT) begin
      slave_idx_out = `SBDA_SLV_APB;
      hit_out       = 1'b1;
      apb_group_out = `SBDA_GRP_SYS;
    end else if (a >= `SBDA_TIM_BASE && a < `SBDA_TIM_LIMIT) begin
      slave_idx_out = `SBDA_SLV_APB;
      hit_out       = 1'b1;
      apb_group_out = `SBDA_GRP_TIM;
      apb_wide_out  = 1'b1;
    end else if (a >= `SBDA_PPB_BASE && a < `SBDA_PPB_LIMIT) begin
      slave_idx_out = `SBDA_SLV_PPB;
      hit_out       = 1'b1;
    end
  end

endmodule // sbda_addr_decode

// File: logic/sbda_bus_fabric.v
// Bus fabric: two-master arbiter, address decode and peripheral bridges
`timescale 1ns/100ps
`include "sbda_regs.vh"

module sbda_bus_fabric (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_b_in,
  // Control
  input  wire        bus_master_priority_sel_in,
  input  wire [1:0]  boot_remap_select_in,
  // Core master
  input  wire [1:0]  cpu_htrans_in,
  input  wire [31:0] cpu_haddr_in,
  input  wire        cpu_hwrite_in,
  input  wire [2:0]  cpu_hsize_in,
  input  wire [31:0] cpu_hwdata_in,
  // DMA master
  input  wire [1:0]  dma_htrans_in,
  input  wire [31:0] dma_haddr_in,
  input  wire        dma_hwrite_in,
  input  wire [2:0]  dma_hsize_in,
  input  wire [31:0] dma_hwdata_in,
  // Master answers
  output reg         cpu_hgrant_out,
  output reg         dma_hgrant_out,
  output reg         hready_out,
  output reg         hresp_out,
  output reg  [31:0] hrdata_out,
  // AHB slave side
  output reg  [7:0]  hsel_out,
  output reg  [31:0] haddr_out,
  output reg         hwrite_out,
  output reg  [2:0]  hsize_out,
  output reg  [1:0]  htrans_out,
  output reg  [31:0] hwdata_out,
  output reg  [1:0]  ram_bank_sel_out,
  input  wire [255:0] slv_hrdata_in,
  input  wire [7:0]  slv_hreadyout_in,
  input  wire [7:0]  slv_hresp_in,
  // Peripheral buses
  output reg  [7:0]  nar_psel_out,
  output reg  [1:0]  nar_domain_out,
  output reg  [7:0]  wide_psel_out,
  output reg         penable_out,
  output reg         pwrite_out,
  output reg  [15:0] paddr_out,
  output reg  [31:0] pwdata_out,
  input  wire [15:0] nar_prdata_in,
  input  wire [31:0] wide_prdata_in,
  input  wire        pready_in
);

  // ====================================================================
  // Bridge states
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETUP  = 2'h1;
  localparam [1:0] ST_ACCESS = 2'h2;
  localparam [1:0] ST_ERR    = 2'h3;

  reg        own_dma_q;
  reg        dphase_q;
  reg        dsel_err_q;
  reg [2:0]  dslv_q;
  reg        dapb_q;
  reg        dwide_q;
  reg [1:0]  st_q;
  reg [1:0]  grp_q;
  reg [2:0]  win_q;
  reg        wide_q;
  reg [15:0] paddr_q;

  wire        cpu_req = cpu_htrans_in[1];
  wire        dma_req = dma_htrans_in[1];
  wire        busy    = dphase_q;
  wire        own_nx;
  wire [1:0]  m_trans = own_dma_q ? dma_htrans_in : cpu_htrans_in;
  wire [31:0] m_addr  = own_dma_q ? dma_haddr_in  : cpu_haddr_in;
  wire        m_write = own_dma_q ? dma_hwrite_in : cpu_hwrite_in;
  wire [2:0]  m_size  = own_dma_q ? dma_hsize_in  : cpu_hsize_in;
  wire [31:0] m_wdata = own_dma_q ? dma_hwdata_in : cpu_hwdata_in;
  wire        take    = m_trans[1] && hready_out;

  wire [2:0]  dec_slv;
  wire        dec_hit;
  wire [1:0]  dec_grp;
  wire        dec_wide;
  wire [2:0]  dec_win;
  wire [1:0]  dec_bank;
  wire [31:0] dec_addr;

  sbda_addr_decode u_dec (
    .addr_in              (m_addr),
    .boot_remap_select_in (boot_remap_select_in),
    .slave_idx_out        (dec_slv),
    .hit_out              (dec_hit),
    .apb_group_out        (dec_grp),
    .apb_wide_out         (dec_wide),
    .apb_window_out       (dec_win),
    .ram_bank_out         (dec_bank),
    .phys_addr_out        (dec_addr)
  );

  // ====================================================================
  // Arbiter
  // Priority bit picks winner
  assign own_nx = (cpu_req && dma_req) ? (bus_master_priority_sel_in != `SBDA_PRIO_CPU) :
                  dma_req ? 1'b1 : cpu_req ? 1'b0 : own_dma_q;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      own_dma_q      <= 1'b0;
      cpu_hgrant_out <= 1'b1;
      dma_hgrant_out <= 1'b0;
    end else if (hready_out && !take && !busy) begin
      own_dma_q      <= own_nx;
      cpu_hgrant_out <= !own_nx;
      dma_hgrant_out <= own_nx;
    end
  end

  // ====================================================================
  // Address phase capture and AHB slave drive
  genvar g;
  wire [31:0] slv_rd [0:`SBDA_NSLV-1];
  generate
    for (g = 0; g < `SBDA_NSLV; g = g + 1) begin : g_rd
      assign slv_rd[g] = slv_hrdata_in[g*32+31:g*32];
    end
  endgenerate

  wire d_ahb = dphase_q && !dapb_q && !dsel_err_q;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dphase_q   <= 1'b0;
      dsel_err_q <= 1'b0;
      dslv_q     <= `SBDA_SLV_ROM;
      dapb_q     <= 1'b0;
      dwide_q    <= 1'b0;
      hsel_out   <= 8'h00;
      haddr_out  <= 32'h0000_0000;
      hwrite_out <= 1'b0;
      hsize_out  <= 3'h0;
      htrans_out <= `SBDA_HTRANS_IDLE;
      hwdata_out <= 32'h0000_0000;
      ram_bank_sel_out <= 2'h0;
    end else begin
      hwdata_out <= m_wdata;
      if (hready_out) begin
        dphase_q   <= take;
        dsel_err_q <= take && !dec_hit;
        dslv_q     <= dec_slv;
        dapb_q     <= take && dec_hit && (dec_slv == `SBDA_SLV_APB);
        dwide_q    <= dec_wide;
        hsel_out   <= (take && dec_hit && dec_slv != `SBDA_SLV_APB) ? (8'h01 << dec_slv) : 8'h00;
        haddr_out  <= dec_addr;
        hwrite_out <= m_write;
        hsize_out  <= m_size;
        htrans_out <= (take && dec_hit && dec_slv != `SBDA_SLV_APB) ? `SBDA_HTRANS_NONSEQ
                                                                    : `SBDA_HTRANS_IDLE;
        ram_bank_sel_out <= dec_bank;
      end else if (d_ahb) begin
        htrans_out <= `SBDA_HTRANS_IDLE;
      end
    end
  end

  // ====================================================================
  // Peripheral bridges and response
  // Two bridges share one sequencer
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q           <= ST_IDLE;
      grp_q          <= `SBDA_GRP_NONE;
      win_q          <= 3'h0;
      wide_q         <= 1'b0;
      paddr_q        <= 16'h0000;
      nar_psel_out   <= 8'h00;
      wide_psel_out  <= 8'h00;
      nar_domain_out <= `SBDA_GRP_NONE;
      penable_out    <= 1'b0;
      pwrite_out     <= 1'b0;
      paddr_out      <= 16'h0000;
      pwdata_out     <= 32'h0000_0000;
      hready_out     <= 1'b1;
      hresp_out      <= 1'b0;
      hrdata_out     <= 32'h0000_0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          hresp_out <= 1'b0;
          if (hready_out && take && !dec_hit) begin
            st_q       <= ST_ERR;
            hready_out <= 1'b0;
            hresp_out  <= 1'b1;
            hrdata_out <= 32'h0000_0000;
          end else if (hready_out && take && dec_slv == `SBDA_SLV_APB) begin
            st_q       <= ST_SETUP;
            hready_out <= 1'b0;
            grp_q      <= dec_grp;
            win_q      <= dec_win;
            wide_q     <= dec_wide;
            paddr_q    <= dec_addr[15:0];
            pwrite_out <= m_write;
          end else if (hready_out && take) begin
            // Data phase of a memory slave holds the master until the slave answers
            hready_out <= 1'b0;
          end else if (d_ahb && !hready_out) begin
            hready_out <= slv_hreadyout_in[dslv_q];
            hresp_out  <= slv_hresp_in[dslv_q];
            hrdata_out <= slv_rd[dslv_q];
          end else begin
            hready_out <= 1'b1;
          end
        end
        ST_SETUP: begin
          // Write data taken here is hwdata_out as registered at the address phase edge, not the data-phase word
          pwdata_out <= hwdata_out;
          paddr_out  <= paddr_q;
          if (wide_q) begin
            wide_psel_out <= 8'h01 << win_q;
          end else begin
            nar_psel_out   <= 8'h01 << win_q;
            nar_domain_out <= grp_q;
          end
          st_q <= ST_ACCESS;
        end
        ST_ACCESS: begin
          penable_out <= 1'b1;
          if (penable_out && pready_in) begin
            penable_out   <= 1'b0;
            nar_psel_out  <= 8'h00;
            wide_psel_out <= 8'h00;
            hready_out    <= 1'b1;
            hrdata_out    <= wide_q ? wide_prdata_in : {16'h0000, nar_prdata_in};
            st_q          <= ST_IDLE;
          end
        end
        ST_ERR: begin
          hready_out <= 1'b1;
          st_q       <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sbda_bus_fabric

// File: verification/sbda_fabric_sva.sv
// Port checker of the bus fabric
`timescale 1ns/100ps
module sbda_fabric_sva (
  // Clock, reset, control
  input wire         ref_clk_in,
  input wire         rst_b_in,
  input wire         bus_master_priority_sel_in,
  input wire [1:0]   cpu_htrans_in,
  input wire [1:0]   dma_htrans_in,
  // Answers and selects
  input wire         cpu_hgrant_out,
  input wire         dma_hgrant_out,
  input wire         hready_out,
  input wire         hresp_out,
  input wire [7:0]   hsel_out,
  input wire [31:0]  haddr_out,
  input wire [1:0]   ram_bank_sel_out,
  input wire [7:0]   nar_psel_out,
  input wire [1:0]   nar_domain_out,
  input wire [7:0]   wide_psel_out,
  input wire         penable_out,
  input wire         pready_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire both_req = cpu_htrans_in[1] & dma_htrans_in[1];
  wire psel_any = (|nar_psel_out) | (|wide_psel_out);
  wire taken    = hready_out & (cpu_hgrant_out & cpu_htrans_in[1] | dma_hgrant_out & dma_htrans_in[1]);
  sequence err_first; hresp_out && !hready_out; endsequence
  sequence err_last;  hresp_out && hready_out;  endsequence
  sequence apb_setup;  psel_any && !penable_out; endsequence
  sequence apb_access; psel_any && penable_out;  endsequence
  // ==========
  // Arbitration
  one_owner_a: assert property (cpu_hgrant_out ^ dma_hgrant_out)
    else $error("grant not one-hot");
  take_hold_a: assert property (taken |=> $stable(cpu_hgrant_out))
    else $error("owner changed at a taken transfer");
  data_hold_a: assert property (!hready_out |=> $stable(dma_hgrant_out))
    else $error("owner changed in a data phase");
  core_prio_a: assert property (cpu_hgrant_out && both_req && !bus_master_priority_sel_in
    |=> cpu_hgrant_out)
    else $error("core lost the bus to lower priority");
  dma_prio_a: assert property (dma_hgrant_out && both_req && bus_master_priority_sel_in
    |=> dma_hgrant_out)
    else $error("dma lost the bus to lower priority");
  // ==========
  // Errors and selects
  err_nosel_a: assert property ($rose(hresp_out) |-> hsel_out == 8'h0 && !psel_any)
    else $error("error answer with a select");
  err_steps_a: assert property ($rose(hresp_out) |-> err_first ##1 err_last)
    else $error("error answer not two cycles");
  bus_excl_a: assert property ($onehot0({hsel_out[6:0], |nar_psel_out, |wide_psel_out}))
    else $error("two targets selected");
  sleep_win_a: assert property (nar_domain_out == 2'h1 && psel_any |-> nar_psel_out[7:3] == 5'h0)
    else $error("sleep window out of range");
  sys_win_a: assert property (|nar_psel_out |-> nar_domain_out inside {2'h1, 2'h2})
    else $error("narrow select without domain");
  wide_win_a: assert property (|wide_psel_out |-> wide_psel_out inside {8'h01, 8'h02})
    else $error("wide select out of range");
  apb_seq_a: assert property ($rose(psel_any) |-> apb_setup ##1 apb_access)
    else $error("peripheral setup then access broken");
  apb_done_a: assert property (apb_access and pready_in |=> hready_out)
    else $error("peripheral end not answered");
  bank_top_a: assert property (hsel_out[3] && haddr_out[31:12] >= 20'h07fc7
    |-> ram_bank_sel_out == 2'h2)
    else $error("third bank not chosen");
  ppb_route_a: assert property (hsel_out[6] |-> haddr_out[31:20] == 12'he00)
    else $error("private bus select off its region");
endmodule // sbda_fabric_sva

bind sbda_bus_fabric sbda_fabric_sva i_sbda_fabric_sva (.ref_clk_in, .rst_b_in,
  .bus_master_priority_sel_in, .cpu_htrans_in, .dma_htrans_in, .cpu_hgrant_out,
  .dma_hgrant_out, .hready_out, .hresp_out, .hsel_out, .haddr_out, .ram_bank_sel_out,
  .nar_psel_out, .nar_domain_out, .wide_psel_out, .penable_out, .pready_in);

// File: verification/sbda_master_model.sv
// Bus master model standing for the core or the DMA engine
`timescale 1ns/100ps
module sbda_master_model (
  // Clock and answers
  input  wire         ref_clk_in,
  input  wire         hgrant_in,
  input  wire         hready_in,
  // Master phase
  output logic [1:0]  htrans_out,
  output logic [31:0] haddr_out,
  output logic        hwrite_out,
  output logic [2:0]  hsize_out,
  output logic [31:0] hwdata_out
);
  initial begin
    htrans_out = 2'h0;
    haddr_out = 32'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
  end
  // one word, held until owner and ready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output bit ok);
    int n;
    ok = 0;
    htrans_out = 2'h2;
    haddr_out = a;
    hwrite_out = w;
    for (n = 0; n < 300 && !ok; n++) begin
      ok = hgrant_in === 1'b1 && hready_in === 1'b1;
      @(negedge ref_clk_in);
    end
    // Released address flips so a stale value never passes
    htrans_out = 2'h0;
    haddr_out = ~a;
    hwdata_out = d;
    for (n = 0; n < 300 && ok; n++) begin
      if (hready_in === 1'b1) break;
      @(negedge ref_clk_in);
    end
    ok = ok && hready_in === 1'b1;
  endtask
endmodule // sbda_master_model

// File: verification/sbda_bus_fabric_bench.sv
// Self-checking bench of the bus fabric
`timescale 1ns/100ps
module sbda_bus_fabric_bench;
  logic ref_clk_in, rst_b_in, bus_master_priority_sel_in, pready_in;
  logic [1:0] boot_remap_select_in, cpu_htrans_in, dma_htrans_in, htrans_out, ram_bank_sel_out;
  logic [1:0] nar_domain_out;
  logic [31:0] cpu_haddr_in, cpu_hwdata_in, dma_haddr_in, dma_hwdata_in, hrdata_out, haddr_out;
  logic [31:0] hwdata_out, pwdata_out, wide_prdata_in;
  logic [2:0] cpu_hsize_in, dma_hsize_in, hsize_out;
  logic cpu_hwrite_in, dma_hwrite_in, cpu_hgrant_out, dma_hgrant_out, hready_out, hresp_out;
  logic hwrite_out, penable_out, pwrite_out;
  logic [255:0] slv_hrdata_in;
  logic [7:0] slv_hreadyout_in, slv_hresp_in, hsel_out, nar_psel_out, wide_psel_out;
  logic [15:0] paddr_out, nar_prdata_in;
  logic [59:0] q[2][$];
  logic [31:0] amap[$] = '{32'h07f00000, 32'h07f23ffc, 32'h07f24000, 32'h07f40000,
    32'h07f400fc, 32'h07f40100, 32'h07f80000, 32'h07f87ffc, 32'h07f88000, 32'h07fbfffc,
    32'h07fc0000, 32'h07fc3ffc, 32'h07fc4000, 32'h07fc6ffc, 32'h07fc7000, 32'h07fcbffc,
    32'h07fcc000, 32'h40000000, 32'h40000ffc, 32'h40001000, 32'h40003ffc, 32'h40004000,
    32'h50000300, 32'h50001700, 32'h50003700, 32'h50004000, 32'h50004100, 32'h50004200,
    32'he0000000, 32'he00ffffc, 32'he0100000, 32'h04000000, 32'h07effffc};
  int error_cnt = 0;
  int n_tests = 0;
  logic pend = 0, own, rd;
  int cnt;
  logic [6:0] ah;
  logic [7:0] an, aw;
  logic [1:0] ad, ab;

  sbda_bus_fabric i_sbda_bus_fabric (.ref_clk_in, .rst_b_in, .bus_master_priority_sel_in,
    .boot_remap_select_in, .cpu_htrans_in, .cpu_haddr_in, .cpu_hwrite_in, .cpu_hsize_in,
    .cpu_hwdata_in, .dma_htrans_in, .dma_haddr_in, .dma_hwrite_in, .dma_hsize_in,
    .dma_hwdata_in, .cpu_hgrant_out, .dma_hgrant_out, .hready_out, .hresp_out, .hrdata_out,
    .hsel_out, .haddr_out, .hwrite_out, .hsize_out, .htrans_out, .hwdata_out,
    .ram_bank_sel_out, .slv_hrdata_in, .slv_hreadyout_in, .slv_hresp_in, .nar_psel_out,
    .nar_domain_out, .wide_psel_out, .penable_out, .pwrite_out, .paddr_out, .pwdata_out,
    .nar_prdata_in, .wide_prdata_in, .pready_in);
  sbda_master_model i_cpu (.ref_clk_in, .hgrant_in(cpu_hgrant_out), .hready_in(hready_out),
    .htrans_out(cpu_htrans_in), .haddr_out(cpu_haddr_in), .hwrite_out(cpu_hwrite_in),
    .hsize_out(cpu_hsize_in), .hwdata_out(cpu_hwdata_in));
  sbda_master_model i_dma (.ref_clk_in, .hgrant_in(dma_hgrant_out), .hready_in(hready_out),
    .htrans_out(dma_htrans_in), .haddr_out(dma_haddr_in), .hwrite_out(dma_hwrite_in),
    .hsize_out(dma_hsize_in), .hwdata_out(dma_hwdata_in));

  initial begin
    ref_clk_in = 0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  function automatic bit inr(input logic [31:0] a, lo, hi);
    return a >= lo && a < hi;
  endfunction

  // Expected {selects, domain, bank, error, read data}
  function automatic logic [59:0] expect_of(input logic [31:0] a, input logic w);
    logic [6:0] hs = 0;
    logic [7:0] np = 0, wp = 0;
    logic [1:0] dm = 0, bk = 0;
    logic er = 0;
    logic [31:0] d = 0;
    if (a < 32'h04000000)
      a = a | (boot_remap_select_in == 2'h1 ? 32'h07f80000 :
               boot_remap_select_in == 2'h2 ? 32'h07fc0000 : 32'h07f00000);
    if (inr(a, 32'h07f00000, 32'h07f24000)) hs = 1;
    else if (inr(a, 32'h07f40000, 32'h07f40100)) hs = 2;
    else if (inr(a, 32'h07f80000, 32'h07f88000)) hs = 4;
    else if (inr(a, 32'h07fc0000, 32'h07fcc000)) begin
      hs = 8;
      bk = a < 32'h07fc4000 ? 2'h0 : a < 32'h07fc7000 ? 2'h1 : 2'h2;
    end
    else if (inr(a, 32'h40000000, 32'h40001000)) hs = 16;
    else if (inr(a, 32'h40001000, 32'h40004000)) hs = 32;
    else if (inr(a, 32'he0000000, 32'he0100000)) hs = 64;
    else if (inr(a, 32'h50000000, 32'h50000300)) begin
      np = 8'h1 << a[10:8];
      dm = 2'h1;
    end
    else if (inr(a, 32'h50001000, 32'h50001700) || inr(a, 32'h50003000, 32'h50003700)) begin
      np = 8'h1 << a[10:8];
      dm = 2'h2;
    end
    else if (inr(a, 32'h50004000, 32'h50004200)) wp = 8'h1 << a[8];
    else er = 1;
    for (int i = 0; i < 7; i++) if (hs[i]) d = slv_hrdata_in[i*32 +: 32];
    if (|np) d = {16'h0, nar_prdata_in};
    if (|wp) d = wide_prdata_in;
    return {hs, np, wp, dm, bk, er, (w || er) ? 32'h0 : d};
  endfunction

  task check(input logic [59:0] seen, input logic [59:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t result %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run(input bit m, input logic [31:0] a);
    logic w;
    logic [31:0] d;
    bit ok;
    w = $urandom % 2;
    d = $urandom;
    q[m].push_back(expect_of(a, w));
    if (m) i_dma.xfer(a, w, d, ok);
    else i_cpu.xfer(a, w, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("FAIL %0t transfer never finished", $time);
      conclude();
    end
  endtask

  // ==========
  // Result watcher
  always @(posedge ref_clk_in) if (rst_b_in && hready_out === 1'b1 && (cpu_hgrant_out
      && cpu_htrans_in[1] || dma_hgrant_out && dma_htrans_in[1])) begin
    pend = 1;
    own = dma_hgrant_out;
    rd = !(dma_hgrant_out ? dma_hwrite_in : cpu_hwrite_in);
    {cnt, ah, an, aw, ad, ab} = 0;
  end
  always @(negedge ref_clk_in) if (pend) begin
    // First cycle already shows this transfer's AHB selects and is not sampled
    if (cnt > 0) begin
      ah = ah | hsel_out[6:0];
      an = an | nar_psel_out;
      aw = aw | wide_psel_out;
      if (|nar_psel_out) ad = ad | nar_domain_out;
      if (hsel_out[3]) ab = ram_bank_sel_out;
      if (penable_out === 1'b1) check(pwrite_out, !rd);
    end
    cnt++;
    if (hready_out === 1'b1) begin
      pend = 0;
      check({ah, an, aw, ad, ab, hresp_out, (rd && !hresp_out) ? hrdata_out : 32'h0},
            q[own].size() ? q[own].pop_front() : 60'hx);
    end
  end

  // Slaves stall at random
  always @(negedge ref_clk_in) begin
    slv_hreadyout_in <= ($urandom % 4 != 0) ? 8'hff : 8'h00;
    pready_in <= $urandom % 3 != 0;
  end

  initial begin
    void'($urandom(70));
    rst_b_in = 0;
    bus_master_priority_sel_in = 0;
    boot_remap_select_in = 2'h0;
    slv_hreadyout_in = 8'hff;
    slv_hresp_in = 8'h00;
    pready_in = 1;
    for (int i = 0; i < 8; i++) slv_hrdata_in[i*32 +: 32] = $urandom;
    nar_prdata_in = $urandom;
    wide_prdata_in = $urandom;
    for (int k = 0; k < 7; k++) begin
      amap.push_back(32'h50001000 + (k << 8));
      amap.push_back(32'h50003000 + (k << 8));
      if (k < 3) amap.push_back(32'h50000000 + (k << 8));
    end
    repeat (12) @(negedge ref_clk_in);
    rst_b_in = 1;
    @(negedge ref_clk_in);
    // Every region edge, masters taking turns
    foreach (amap[i]) run(i % 2, amap[i]);
    $display("test address map done");
    // Every boot remap code
    for (int r = 0; r < 4; r++) begin
      boot_remap_select_in = r;
      repeat (3) run(0, ($urandom % 32'h1000) << 2);
    end
    boot_remap_select_in = 2'h0;
    $display("test remap done");
    // Both masters contend under each priority
    for (int p = 0; p < 2; p++) begin
      bus_master_priority_sel_in = p;
      fork
        repeat (8) run(0, amap[$urandom % amap.size()]);
        repeat (8) run(1, amap[$urandom % amap.size()]);
      join
    end
    $display("test contention done");
    for (int n = 0; n < 50 && (q[0].size() || q[1].size()); n++) @(negedge ref_clk_in);
    if (q[0].size() || q[1].size()) begin
      error_cnt++;
      $display("FAIL %0t results missing", $time);
    end
    conclude();
  end
endmodule // sbda_bus_fabric_bench
